// file: core/sshp_pkg.sv
package sshp_pkg;
	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int SSHP_WORD_BITS = 8;
	localparam int SSHP_SYNC_STAGES = 2;
	// strap is taken once, on the mclk edge after the counter reaches this value (third cycle after reset release)
	localparam logic [1:0] SSHP_STRAP_TAKE_CNT = 2'h2;
	// ----------------------------------------------------------------
	// reset values and last bit index
	// ----------------------------------------------------------------
	localparam logic [7:0] SSHP_WORD_RST = 8'h00;
	localparam logic [2:0] SSHP_BITS_RST = 3'h0;
	localparam logic [2:0] SSHP_BITS_LAST = 3'h7;
endpackage

// file: core/sshp_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// two-stage level synchroniser, one per bit
// ----------------------------------------------------------------
module sshp_sync
	import sshp_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	// refuse widths the synchroniser cannot serve
	if (WIDTH < 1) begin : g_bad_width
		$error("sshp_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule // sshp_sync

// file: core/sshp_port.sv
`timescale 1ns/10ps
// Function
// - interface active only while select is low
// - interrupt output high means interrupt pending
// - strap low: sample rising, launch falling
// - strap high: sample falling, launch rising
module sshp_port
	import sshp_pkg::*;
#(
	parameter int WORD_BITS = SSHP_WORD_BITS
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic port_select_n,
	input wire logic clock_edge_strap,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	output logic host_irq_out,
	input wire logic irq_request,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_load,
	output logic tx_ready,
	output logic port_active
);
	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] shift;
		logic [7:0] hold;
		logic tgl;
	} sshp_samp_type;

	typedef struct packed {
		logic [7:0] shift;
		logic tgl;
	} sshp_launch_type;

	typedef struct packed {
		logic strap;
		logic [1:0] strap_cnt;
		logic rx_seen;
		logic ack_seen;
		logic [7:0] rx_data;
		logic rx_valid;
		logic [7:0] tx_word;
		logic tx_pend;
		logic irq;
		logic active;
	} sshp_core_type;

	sshp_samp_type samp_reg, samp_next;
	sshp_launch_type launch_reg, launch_next;
	sshp_core_type core_reg, core_next;
	logic [2:0] samp_bits_reg;
	logic [2:0] launch_bits_reg;
	logic sclk_eff;
	logic link_rst_n;
	logic [3:0] sync_out;

	// word holders are fixed at eight bits, so refuse any other width
	if (WORD_BITS != SSHP_WORD_BITS) begin : g_bad_width
		$error("sshp_port: only 8-bit words supported");
	end

	// ----------------------------------------------------------------
	// link clock and link reset
	// ----------------------------------------------------------------
	// strap is static after reset, so flipping the clock is glitch free in use
	assign sclk_eff = serial_clock_in ^ core_reg.strap;
	// high select holds bit counters cleared, so clock activity is ignored
	assign link_rst_n = resetn & ~port_select_n;

	// ----------------------------------------------------------------
	// sampling side of the link
	// ----------------------------------------------------------------
	// bit counters restart on each select; word holders survive deselect
	always_ff @(posedge sclk_eff or negedge link_rst_n) begin
		if (!link_rst_n) begin
			samp_bits_reg <= SSHP_BITS_RST;
		end else begin
			samp_bits_reg <= samp_bits_reg + 3'h1;
		end
	end

	// deselected edges leave the sampling registers untouched
	always_comb begin
		samp_next = samp_reg;
		if (!port_select_n) begin
			samp_next.shift = {samp_reg.shift[6:0], serial_data_in};
			if (samp_bits_reg == SSHP_BITS_LAST) begin
				samp_next.hold = samp_next.shift;
				samp_next.tgl = ~samp_reg.tgl;
			end
		end
	end

	// edges also come from a deselected host or a strap flip, hence the gate above
	always_ff @(posedge sclk_eff or negedge resetn) begin
		if (!resetn) begin
			samp_reg <= '0;
		end else begin
			samp_reg <= samp_next;
		end
	end

	// ----------------------------------------------------------------
	// launching side of the link
	// ----------------------------------------------------------------
	always_ff @(negedge sclk_eff or negedge link_rst_n) begin
		if (!link_rst_n) begin
			launch_bits_reg <= SSHP_BITS_RST;
		end else begin
			launch_bits_reg <= launch_bits_reg + 3'h1;
		end
	end

	// strap high: first launch edge comes before any sample, so load whole word
	always_comb begin
		launch_next = launch_reg;
		// a deselected edge must not acknowledge a word that was never sent
		if (!port_select_n) begin
			if (launch_bits_reg == SSHP_BITS_RST) begin
				launch_next.shift = core_reg.strap ? core_reg.tx_word
					: {core_reg.tx_word[6:0], 1'b0};
				launch_next.tgl = ~launch_reg.tgl;
			end else begin
				launch_next.shift = {launch_reg.shift[6:0], 1'b0};
			end
		end
	end

	always_ff @(negedge sclk_eff or negedge resetn) begin
		if (!resetn) begin
			launch_reg <= '0;
		end else begin
			launch_reg <= launch_next;
		end
	end

	// strap low shows the first bit before any clock edge
	always_comb begin
		if (!core_reg.strap && launch_bits_reg == SSHP_BITS_RST) begin
			serial_data_out = core_reg.tx_word[7];
		end else begin
			serial_data_out = launch_reg.shift[7];
		end
	end
	assign serial_data_out_oe = ~port_select_n;

	// ----------------------------------------------------------------
	// crossing into mclk
	// ----------------------------------------------------------------
	sshp_sync #(
		.WIDTH(4)
	) u_sync (
		.mclk(mclk),
		.resetn(resetn),
		.async_in({samp_reg.tgl, launch_reg.tgl, clock_edge_strap, port_select_n}),
		.sync_out(sync_out)
	);

	// ----------------------------------------------------------------
	// mclk side: strap capture, received words, transmit word, irq
	// ----------------------------------------------------------------
	always_comb begin
		core_next = core_reg;
		core_next.rx_valid = 1'b0;
		// strap caught once, a few cycles after release, then frozen
		if (core_reg.strap_cnt != 2'h3) begin
			core_next.strap_cnt = core_reg.strap_cnt + 2'h1;
		end
		if (core_reg.strap_cnt == SSHP_STRAP_TAKE_CNT) begin
			core_next.strap = sync_out[1];
		end
		// hold is stable for a whole word time, far longer than the crossing
		if (sync_out[3] != core_reg.rx_seen) begin
			core_next.rx_seen = sync_out[3];
			core_next.rx_data = samp_reg.hold;
			core_next.rx_valid = 1'b1;
		end
		if (sync_out[2] != core_reg.ack_seen) begin
			core_next.ack_seen = sync_out[2];
			core_next.tx_pend = 1'b0;
		end
		if (tx_load && !core_reg.tx_pend) begin
			core_next.tx_word = tx_data;
			core_next.tx_pend = 1'b1;
		end
		core_next.irq = irq_request;
		core_next.active = ~sync_out[0];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			core_reg <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	assign rx_data = core_reg.rx_data;
	assign rx_valid = core_reg.rx_valid;
	assign tx_ready = ~core_reg.tx_pend;
	assign host_irq_out = core_reg.irq;
	assign port_active = core_reg.active;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic din_rise_reg;
	logic din_fall_reg;
	always_ff @(posedge serial_clock_in) begin
		din_rise_reg <= serial_data_in;
	end
	always_ff @(negedge serial_clock_in) begin
		din_fall_reg <= serial_data_in;
	end

	irq_level_a: assert property (@(posedge mclk) disable iff (!resetn)
		irq_request |=> host_irq_out)
		else $error("interrupt output did not follow request");
	irq_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
		!irq_request ##1 !irq_request |-> !host_irq_out)
		else $error("interrupt output high with nothing pending");
	rise_sample_a: assert property (@(negedge serial_clock_in)
		disable iff (!resetn || port_select_n)
		(!core_reg.strap && samp_bits_reg != SSHP_BITS_RST) |-> samp_reg.shift[0] == din_rise_reg)
		else $error("strap low: data not sampled on rising edge");
	fall_sample_a: assert property (@(posedge serial_clock_in)
		disable iff (!resetn || port_select_n)
		(core_reg.strap && samp_bits_reg != SSHP_BITS_RST) |-> samp_reg.shift[0] == din_fall_reg)
		else $error("strap high: data not sampled on falling edge");
	deselect_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
		port_select_n [*2] |-> samp_bits_reg == SSHP_BITS_RST && launch_bits_reg == SSHP_BITS_RST
		&& !serial_data_out_oe && $stable(samp_reg) && $stable(launch_reg))
		else $error("link state advanced while deselected");
endmodule // sshp_port

// file: bench/sshp_host.sv
`timescale 1ns/10ps
// ------------------------
// host master model
// ------------------------
module sshp_host (
	output logic sclk,
	output logic mosi,
	output logic csn,
	input wire logic miso,
	input wire logic strap
);
	// clock idles low and stands still between frames
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		csn = 1'b1;
	end
	// one byte each way, msb first; sel low keeps the port deselected
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic sel);
		int i;
		csn = ~sel;
		#20;
		for (i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#12;
			if (!strap) rx[i] = miso;
			sclk = 1'b1;
			#24;
			if (strap) rx[i] = miso;
			sclk = 1'b0;
			#12;
		end
		mosi = ~mosi; // released line must not look like held data
		csn = 1'b1;
		#60;
	endtask
endmodule // sshp_host

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sshp_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic strap = 1'b0;
	logic irq_request = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_load = 1'b0;
	logic sclk, mosi, csn, miso, oe, irq, rx_valid, tx_ready;
	logic [7:0] rx_data, rx_got;
	logic miso_bus;
	logic act;
	int err_count = 0;
	int checks_done = 0;
	int rx_cnt = 0;
	int act_cnt = 0;
	int cyc = 0;
	always #10 mclk = ~mclk;
	sshp_port i_sshp_port (.mclk(mclk), .resetn(resetn), .serial_clock_in(sclk),
		.serial_data_in(mosi), .port_select_n(csn), .clock_edge_strap(strap),
		.serial_data_out(miso), .serial_data_out_oe(oe), .host_irq_out(irq),
		.irq_request(irq_request), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_load(tx_load), .tx_ready(tx_ready), .port_active(act));
	// undriven data line shows the inverse, so a stale bit cannot pass
	assign miso_bus = oe ? miso : ~miso;
	sshp_host host_m (.sclk(sclk), .mosi(mosi), .csn(csn), .miso(miso_bus), .strap(strap));
	// ------------------------
	// monitors and helpers
	// ------------------------
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) begin
			rx_got <= rx_data;
			rx_cnt <= rx_cnt + 1;
		end
		if (act === 1'b1) begin
			act_cnt <= act_cnt + 1;
		end
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic s);
		@(negedge mclk) resetn = 1'b0;
		strap = s;
		repeat (4) @(negedge mclk);
		resetn = 1'b1;
		repeat (6) @(negedge mclk);
	endtask
	// ------------------------
	// scenarios
	// ------------------------
	task automatic test_xfer(input logic [7:0] dev, input logic [7:0] h);
		logic [7:0] got;
		int n0, k, a0;
		@(negedge mclk);
		for (k = 0; k < 50 && tx_ready !== 1'b1; k++) @(negedge mclk);
		tx_data = dev;
		tx_load = 1'b1;
		@(negedge mclk) tx_load = 1'b0;
		n0 = rx_cnt;
		a0 = act_cnt;
		host_m.xfer(h, got, 1'b1);
		for (k = 0; k < 50 && rx_cnt == n0; k++) @(negedge mclk);
		chk(rx_got, h);
		chk(got, dev);
		chk({7'h00, act_cnt != a0}, 8'h01);
		$display("test xfer %h/%h done", dev, h);
	endtask
	// a word loaded before deselected clocking must still be pending after it
	task automatic test_desel(input logic [7:0] dev);
		logic [7:0] got;
		int n0, a0;
		@(negedge mclk) tx_data = dev;
		tx_load = 1'b1;
		@(negedge mclk) tx_load = 1'b0;
		n0 = rx_cnt;
		a0 = act_cnt;
		host_m.xfer(8'hFF, got, 1'b0);
		repeat (20) @(negedge mclk);
		chk(8'(rx_cnt - n0), 8'h00);
		chk({7'h00, oe}, 8'h00);
		chk({7'h00, tx_ready}, 8'h00);
		chk(8'(act_cnt - a0), 8'h00);
		$display("test deselect done");
	endtask
	task automatic test_irq();
		@(negedge mclk) irq_request = 1'b1;
		@(negedge mclk) chk({7'h00, irq}, 8'h01);
		irq_request = 1'b0;
		@(negedge mclk) chk({7'h00, irq}, 8'h00);
		$display("test irq done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		do_reset(1'b0);
		test_xfer(8'hA5, 8'h3C);
		test_desel(8'h5A);
		test_xfer(8'h5A, 8'hC3);
		test_irq();
		do_reset(1'b1);
		test_xfer(8'h96, 8'h69);
		summarize();
	end
endmodule // testbench
